/* File: verilog/fvm_channel.sv */
// One value mapping channel between group values and Modbus word registers.
// Assumes an APB master for setup and a Modbus master framer on mb_req/rsp.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps

// What this block does
// - Group value vs threshold; per outcome write the field or do nothing.
// - Field vs threshold; per outcome send a group value or do nothing.
// - Field located by bit count and offset from the register's low end.
// - Bit count plus offset above sixteen marks the setup invalid.
// - Comparison reaction values written into a field must fit its bit count.
// - Unsigned two-byte value uses the whole register or a field.
// - Signed two-byte value always fills the whole sixteen-bit register.
// - Float in one register uses one of six areas.
// - Float conversion is linear between configured min and max pairs.
// - Scaled result fills the whole area; register min/max do not clamp.
// - Double word split over two registers, high word first or second.
// - Double word holds unsigned, two's complement or IEEE float.
// - Double word write uses one code 16 or two code 06 requests.
// - Double word read fetches both registers in one request.
// - Double word uses the base address and the next one.
// - Negative register values are two's complement, -32768 to 32767.
// - No answer within one second resends the request up to twice.
// - After all retries fail, every channel of the page is skipped.
// - Acknowledge from a slow slave restarts the answer timeout.
module fvm_channel #(
  parameter int unsigned TIMEOUT_CYC = fvm_pkg::RSP_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic knx_rx_valid,
  input wire logic [31:0] knx_rx_value,
  output logic knx_rx_ready,
  output logic knx_tx_valid,
  output logic [31:0] knx_tx_value,
  output logic mb_req_valid,
  input wire logic mb_req_ready,
  output fvm_pkg::fvm_req_t mb_req,
  input wire logic mb_rsp_valid,
  input wire fvm_pkg::fvm_rsp_t mb_rsp,
  input wire logic page_skip_in,
  output logic page_skip_out
);
  import fvm_pkg::*;

  function automatic logic [15:0] fmask(input logic [4:0] cnt,
                                        input logic [3:0] off);
    logic [16:0] m;
    m = (17'h00001 << cnt) - 17'h00001;
    fmask = m[15:0] << off;
  endfunction : fmask

  function automatic logic [15:0] fget(input logic [15:0] w,
                                       input logic [4:0] cnt,
                                       input logic [3:0] off);
    fget = (w & fmask(cnt, off)) >> off;
  endfunction : fget

  function automatic logic [15:0] fput(input logic [15:0] w,
                                       input logic [15:0] v,
                                       input logic [4:0] cnt,
                                       input logic [3:0] off);
    fput = (w & ~fmask(cnt, off)) | ((v << off) & fmask(cnt, off));
  endfunction : fput

  function automatic logic fits(input logic [31:0] v, input logic [4:0] cnt);
    fits = (v >> cnt) == 32'h0;
  endfunction : fits

  function automatic logic [1:0] cmp3(input logic signed [31:0] a,
                                      input logic signed [31:0] b);
    if (a > b) cmp3 = 2'(OC_HI);
    else if (a == b) cmp3 = 2'(OC_EQ);
    else cmp3 = 2'(OC_LO);
  endfunction : cmp3

  function automatic logic [31:0] lin(input logic signed [31:0] x,
                                      input logic signed [31:0] x0,
                                      input logic signed [31:0] x1,
                                      input logic signed [31:0] y0,
                                      input logic signed [31:0] y1);
    logic signed [63:0] sx, sx0, sx1, sy0, sy1, q;
    sx = x;
    sx0 = x0;
    sx1 = x1;
    sy0 = y0;
    sy1 = y1;
    if (sx1 == sx0) q = sy0;
    else q = sy0 + ((sx - sx0) * (sy1 - sy0)) / (sx1 - sx0);
    lin = q[31:0];
  endfunction : lin

  fvm_cfg_t cfg_r;
  fvm_state_t st_r;
  fvm_req_t req_r;
  logic [15:0] sh_lo_r, sh_hi_r;
  logic [31:0] tmr_r;
  logic [1:0] retry_r;
  logic phase_r, is_rd_r, skipped_r, poll_r, skip_pulse_r;
  logic [31:0] knx_tx_value_r;
  logic knx_tx_valid_r;

  // Register access
  logic wr_acc, rd_acc, hit;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign hit = (paddr[1:0] == 2'h0) && (paddr <= A_POLL);
  assign pslverr = psel & penable & ~hit;

  logic [5:0] fld_end;
  logic cfg_bad;
  assign fld_end = {1'b0, cfg_r.cnt} + {2'h0, cfg_r.off};
  always_comb begin
    cfg_bad = 1'b0;
    if (cfg_r.ty == TY_CMP
        || (cfg_r.ty == TY_UNS && cfg_r.area != AR_FULL_U)) begin
      cfg_bad = (cfg_r.cnt == 5'h00) || (fld_end > REG_BITS);
      if (cfg_r.ty == TY_CMP && !cfg_r.dir) begin
        cfg_bad = cfg_bad | ~fits(cfg_r.vhi, cfg_r.cnt)
          | ~fits(cfg_r.veq, cfg_r.cnt) | ~fits(cfg_r.vlo, cfg_r.cnt);
      end
    end
    if (cfg_r.ty == TY_FLT && cfg_r.area > AR_FULL_S) cfg_bad = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RST;
    end else if (wr_acc) begin
      case (paddr)
        A_CTRL: begin
          cfg_r.en <= pwdata[CT_EN];
          cfg_r.dir <= pwdata[CT_DIR];
          cfg_r.ty <= fvm_type_t'(pwdata[CT_TY+:3]);
          cfg_r.area <= fvm_area_t'(pwdata[CT_AREA+:3]);
          cfg_r.lofirst <= pwdata[CT_LOFIRST];
          cfg_r.enc <= fvm_enc_t'(pwdata[CT_ENC+:2]);
          cfg_r.wr_single <= pwdata[CT_WRSINGLE];
        end
        A_FIELD: begin
          cfg_r.cnt <= pwdata[FD_CNT+:5];
          cfg_r.off <= pwdata[FD_OFF+:4];
        end
        A_THR: cfg_r.thr <= pwdata;
        A_VHI: cfg_r.vhi <= pwdata;
        A_VEQ: cfg_r.veq <= pwdata;
        A_VLO: cfg_r.vlo <= pwdata;
        A_ACT: cfg_r.act <= pwdata[2:0];
        A_ADDR: cfg_r.addr <= pwdata[15:0];
        A_KMIN: cfg_r.kmin <= pwdata;
        A_KMAX: cfg_r.kmax <= pwdata;
        A_RMIN: cfg_r.rmin <= pwdata;
        A_RMAX: cfg_r.rmax <= pwdata;
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0;
    if (rd_acc) begin
      case (paddr)
        A_CTRL: begin
          prdata[CT_EN] = cfg_r.en;
          prdata[CT_DIR] = cfg_r.dir;
          prdata[CT_TY+:3] = cfg_r.ty;
          prdata[CT_AREA+:3] = cfg_r.area;
          prdata[CT_LOFIRST] = cfg_r.lofirst;
          prdata[CT_ENC+:2] = cfg_r.enc;
          prdata[CT_WRSINGLE] = cfg_r.wr_single;
        end
        A_FIELD: begin
          prdata[FD_CNT+:5] = cfg_r.cnt;
          prdata[FD_OFF+:4] = cfg_r.off;
        end
        A_THR: prdata = cfg_r.thr;
        A_VHI: prdata = cfg_r.vhi;
        A_VEQ: prdata = cfg_r.veq;
        A_VLO: prdata = cfg_r.vlo;
        A_ACT: prdata = {29'h0, cfg_r.act};
        A_ADDR: prdata = {16'h0, cfg_r.addr};
        A_KMIN: prdata = cfg_r.kmin;
        A_KMAX: prdata = cfg_r.kmax;
        A_RMIN: prdata = cfg_r.rmin;
        A_RMAX: prdata = cfg_r.rmax;
        A_SHLO: prdata = {16'h0, sh_lo_r};
        A_SHHI: prdata = {16'h0, sh_hi_r};
        A_STAT: begin
          prdata[ST_BAD] = cfg_bad;
          prdata[ST_SKIP] = skipped_r;
          prdata[ST_RETRY+:2] = retry_r;
          prdata[ST_BUSY] = st_r != ST_IDLE;
        end
        default: prdata = 32'h0;
      endcase
    end
  end

  // Group value to register words
  logic [1:0] kx_oc;
  logic [31:0] kx_sel, kx_scl, kx_dw;
  logic [15:0] wr_lo, wr_hi;
  logic wr_go;
  always_comb begin
    kx_oc = cmp3(knx_rx_value, cfg_r.thr);
    kx_sel = (kx_oc == 2'(OC_HI)) ? cfg_r.vhi :
             (kx_oc == 2'(OC_EQ)) ? cfg_r.veq : cfg_r.vlo;
    kx_scl = lin(knx_rx_value, cfg_r.kmin, cfg_r.kmax,
                 cfg_r.rmin, cfg_r.rmax);
    kx_dw = (cfg_r.enc == EN_IEEE) ? knx_rx_value : kx_scl;
    wr_lo = sh_lo_r;
    wr_hi = sh_hi_r;
    wr_go = 1'b1;
    case (cfg_r.ty)
      TY_CMP: begin
        wr_go = cfg_r.act[kx_oc];
        wr_lo = fput(sh_lo_r, kx_sel[15:0], cfg_r.cnt, cfg_r.off);
      end
      TY_UNS: begin
        if (cfg_r.area == AR_FULL_U) wr_lo = knx_rx_value[15:0];
        else wr_lo = fput(sh_lo_r, knx_rx_value[15:0], cfg_r.cnt, cfg_r.off);
      end
      TY_SGN: wr_lo = knx_rx_value[15:0];
      TY_FLT: begin
        case (cfg_r.area)
          AR_LO_U, AR_LO_S: wr_lo = {sh_lo_r[15:8], kx_scl[7:0]};
          AR_HI_U, AR_HI_S: wr_lo = {kx_scl[7:0], sh_lo_r[7:0]};
          default: wr_lo = kx_scl[15:0];
        endcase
      end
      TY_DW: begin
        wr_hi = kx_dw[31:16];
        wr_lo = kx_dw[15:0];
      end
      default: wr_go = 1'b0;
    endcase
  end

  // Register words to group value
  logic [15:0] rw0, rw1, rd_hi, rd_lo, rd_fld;
  logic [31:0] rd_raw, rd_val, rd_sel;
  logic [1:0] rd_oc;
  logic rd_go;
  always_comb begin
    rw0 = mb_rsp.d0;
    rw1 = mb_rsp.d1;
    rd_hi = cfg_r.lofirst ? rw1 : rw0;
    rd_lo = cfg_r.lofirst ? rw0 : rw1;
    rd_fld = fget(rw0, cfg_r.cnt, cfg_r.off);
    rd_oc = cmp3({16'h0, rd_fld}, cfg_r.thr);
    rd_sel = (rd_oc == 2'(OC_HI)) ? cfg_r.vhi :
             (rd_oc == 2'(OC_EQ)) ? cfg_r.veq : cfg_r.vlo;
    rd_go = 1'b1;
    case (cfg_r.area)
      AR_LO_U: rd_raw = {24'h0, rw0[7:0]};
      AR_HI_U: rd_raw = {24'h0, rw0[15:8]};
      AR_FULL_U: rd_raw = {16'h0, rw0};
      AR_LO_S: rd_raw = {{24{rw0[7]}}, rw0[7:0]};
      AR_HI_S: rd_raw = {{24{rw0[15]}}, rw0[15:8]};
      default: rd_raw = {{16{rw0[15]}}, rw0};
    endcase
    case (cfg_r.ty)
      TY_CMP: begin
        rd_go = cfg_r.act[rd_oc];
        rd_val = rd_sel;
      end
      TY_UNS: rd_val = (cfg_r.area == AR_FULL_U) ? {16'h0, rw0} :
                       {16'h0, rd_fld};
      TY_SGN: rd_val = {{16{rw0[15]}}, rw0};
      TY_FLT: rd_val = lin(rd_raw, cfg_r.rmin, cfg_r.rmax,
                           cfg_r.kmin, cfg_r.kmax);
      TY_DW: rd_val = (cfg_r.enc == EN_IEEE) ? {rd_hi, rd_lo} :
        lin({rd_hi, rd_lo}, cfg_r.rmin, cfg_r.rmax, cfg_r.kmin, cfg_r.kmax);
      default: rd_val = 32'h0;
    endcase
  end

  // Sequencing events
  logic run_ok, st_wr, st_rd, sent, got_ok, got_ack, tmo, fail, give_up, more;
  assign run_ok = cfg_r.en & ~cfg_bad & ~skipped_r;
  assign knx_rx_ready = (st_r == ST_IDLE);
  assign st_wr = knx_rx_valid & knx_rx_ready & run_ok & ~cfg_r.dir & wr_go;
  assign st_rd = (st_r == ST_IDLE) & poll_r & run_ok & cfg_r.dir & ~st_wr;
  assign sent = (st_r == ST_REQ) & mb_req_ready;
  assign got_ok = (st_r == ST_WAIT) & mb_rsp_valid & (mb_rsp.kind == RK_OK);
  assign got_ack = (st_r == ST_WAIT) & mb_rsp_valid & (mb_rsp.kind == RK_ACK);
  assign tmo = (st_r == ST_WAIT) & ~mb_rsp_valid
             & (tmr_r == 32'(TIMEOUT_CYC - 1));
  assign fail = tmo | ((st_r == ST_WAIT) & mb_rsp_valid
             & (mb_rsp.kind == RK_ERR));
  assign give_up = fail & (retry_r == MAX_RETRY);
  assign more = got_ok & ~is_rd_r & ~phase_r & (req_r.func == FC_WR_SINGLE)
              & (cfg_r.ty == TY_DW);
  assign mb_req_valid = (st_r == ST_REQ);
  assign mb_req = req_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      req_r <= '0;
      phase_r <= 1'b0;
      is_rd_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (st_wr) begin
            st_r <= ST_REQ;
            is_rd_r <= 1'b0;
            phase_r <= 1'b0;
            req_r.addr <= cfg_r.addr;
            if (cfg_r.ty == TY_DW) begin
              req_r.d0 <= cfg_r.lofirst ? wr_lo : wr_hi;
              req_r.d1 <= cfg_r.lofirst ? wr_hi : wr_lo;
              req_r.func <= cfg_r.wr_single ? FC_WR_SINGLE
                : FC_WR_MULTI;
              req_r.qty <= cfg_r.wr_single ? 2'h1 : 2'h2;
            end else begin
              req_r.d0 <= wr_lo;
              req_r.d1 <= 16'h0000;
              req_r.func <= FC_WR_SINGLE;
              req_r.qty <= 2'h1;
            end
          end else if (st_rd) begin
            st_r <= ST_REQ;
            is_rd_r <= 1'b1;
            phase_r <= 1'b0;
            req_r.addr <= cfg_r.addr;
            req_r.func <= FC_RD_MULTI;
            req_r.qty <= (cfg_r.ty == TY_DW) ? 2'h2 : 2'h1;
            req_r.d0 <= 16'h0000;
            req_r.d1 <= 16'h0000;
          end
        end
        ST_REQ: if (sent) st_r <= ST_WAIT;
        ST_WAIT: begin
          if (more) begin
            st_r <= ST_REQ;
            phase_r <= 1'b1;
            req_r.addr <= cfg_r.addr + 16'h0001;
            req_r.d0 <= req_r.d1;
          end else if (got_ok || give_up) begin
            st_r <= ST_IDLE;
          end else if (fail) begin
            st_r <= ST_REQ;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tmr_r <= 32'h0;
    else if (st_r != ST_WAIT || got_ack) tmr_r <= 32'h0;
    else if (!tmo) tmr_r <= tmr_r + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) retry_r <= 2'h0;
    else if (st_wr || st_rd || more) retry_r <= 2'h0;
    else if (fail && !give_up) retry_r <= retry_r + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skipped_r <= 1'b0;
      skip_pulse_r <= 1'b0;
    end else begin
      skip_pulse_r <= give_up;
      if (give_up || page_skip_in) skipped_r <= 1'b1;
      else if (wr_acc && paddr == A_STAT && pwdata[ST_SKIP]) skipped_r <= 1'b0;
    end
  end
  assign page_skip_out = skip_pulse_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) poll_r <= 1'b0;
    else if (wr_acc && paddr == A_POLL && pwdata[0]) poll_r <= 1'b1;
    else if (st_rd) poll_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_lo_r <= 16'h0000;
      sh_hi_r <= 16'h0000;
    end else if (st_wr) begin
      sh_lo_r <= wr_lo;
      sh_hi_r <= wr_hi;
    end else if (got_ok && is_rd_r) begin
      sh_lo_r <= (cfg_r.ty == TY_DW) ? rd_lo : rw0;
      sh_hi_r <= (cfg_r.ty == TY_DW) ? rd_hi : sh_hi_r;
    end else if (wr_acc && paddr == A_SHLO) begin
      sh_lo_r <= pwdata[15:0];
    end else if (wr_acc && paddr == A_SHHI) begin
      sh_hi_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      knx_tx_valid_r <= 1'b0;
      knx_tx_value_r <= 32'h0;
    end else begin
      knx_tx_valid_r <= got_ok & is_rd_r & rd_go;
      if (got_ok && is_rd_r && rd_go) knx_tx_value_r <= rd_val;
    end
  end
  assign knx_tx_valid = knx_tx_valid_r;
  assign knx_tx_value = knx_tx_value_r;

  a_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mb_req_valid && !mb_req_ready |=> mb_req_valid && $stable(mb_req))
    else $error("request changed before it was taken");
  a_multi_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    mb_req_valid && mb_req.func == FC_WR_MULTI |-> mb_req.qty == 2'h2)
    else $error("multi write without two registers");
  a_second_addr: assert property (@(posedge pclk)
    disable iff (!presetn)
    mb_req_valid && phase_r |-> mb_req.addr == cfg_r.addr + 16'h0001)
    else $error("second word not at next address");
  a_dw_read: assert property (@(posedge pclk) disable iff (!presetn)
    mb_req_valid && is_rd_r && cfg_r.ty == TY_DW
    |-> mb_req.func == FC_RD_MULTI && mb_req.qty == 2'h2)
    else $error("double word read not in one request");
  a_retry_step: assert property (@(posedge pclk)
    disable iff (!presetn)
    fail && retry_r < MAX_RETRY
    |=> st_r == ST_REQ && retry_r == $past(retry_r) + 2'h1)
    else $error("timeout did not resend");
  a_ack_restart: assert property (@(posedge pclk)
    disable iff (!presetn)
    got_ack |=> tmr_r == 32'h0 ##1 tmr_r == 32'h1)
    else $error("acknowledge did not restart the timeout");
  a_skip_page: assert property (@(posedge pclk)
    disable iff (!presetn)
    give_up |=> page_skip_out && skipped_r && st_r == ST_IDLE
    ##1 !page_skip_out)
    else $error("failed request did not skip the page");
  a_no_react: assert property (@(posedge pclk) disable iff (!presetn)
    knx_rx_valid && knx_rx_ready && cfg_r.ty == TY_CMP && !wr_go && !cfg_r.dir
    |=> st_r == ST_IDLE && $stable(sh_lo_r))
    else $error("no reaction produced traffic");
  a_bad_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_IDLE && cfg_bad |=> st_r == ST_IDLE)
    else $error("invalid setup started a request");
endmodule : fvm_channel

/* File: verilog/fvm_pkg.sv */
// Constants, register map and carrier types of the field value mapping channel.
// Assumes one 40 MHz APB clock domain shared by the whole channel.
package fvm_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned RSP_TIMEOUT_MS = 1000;
  localparam int unsigned RSP_TIMEOUT_CYC = (CLK_HZ / 1000) * RSP_TIMEOUT_MS;
  localparam logic [1:0] MAX_RETRY = 2'h2;
  localparam logic [5:0] REG_BITS = 6'h10;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FIELD = 8'h04;
  localparam logic [7:0] A_THR = 8'h08;
  localparam logic [7:0] A_VHI = 8'h0C;
  localparam logic [7:0] A_VEQ = 8'h10;
  localparam logic [7:0] A_VLO = 8'h14;
  localparam logic [7:0] A_ACT = 8'h18;
  localparam logic [7:0] A_ADDR = 8'h1C;
  localparam logic [7:0] A_KMIN = 8'h20;
  localparam logic [7:0] A_KMAX = 8'h24;
  localparam logic [7:0] A_RMIN = 8'h28;
  localparam logic [7:0] A_RMAX = 8'h2C;
  localparam logic [7:0] A_SHLO = 8'h30;
  localparam logic [7:0] A_SHHI = 8'h34;
  localparam logic [7:0] A_STAT = 8'h38;
  localparam logic [7:0] A_POLL = 8'h3C;

  localparam int CT_EN = 0;
  localparam int CT_DIR = 1;
  localparam int CT_TY = 2;
  localparam int CT_AREA = 5;
  localparam int CT_LOFIRST = 8;
  localparam int CT_ENC = 9;
  localparam int CT_WRSINGLE = 11;
  localparam int FD_CNT = 0;
  localparam int FD_OFF = 8;
  localparam int ST_BAD = 0;
  localparam int ST_SKIP = 1;
  localparam int ST_RETRY = 2;
  localparam int ST_BUSY = 4;
  localparam int OC_HI = 0;
  localparam int OC_EQ = 1;
  localparam int OC_LO = 2;

  localparam logic [7:0] FC_RD_MULTI = 8'h03;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;

  typedef enum logic [2:0] {
    TY_CMP = 3'h0, TY_UNS = 3'h1, TY_SGN = 3'h2, TY_FLT = 3'h3, TY_DW = 3'h4
  } fvm_type_t;
  typedef enum logic [2:0] {
    AR_LO_U = 3'h0, AR_HI_U = 3'h1, AR_FULL_U = 3'h2,
    AR_LO_S = 3'h3, AR_HI_S = 3'h4, AR_FULL_S = 3'h5
  } fvm_area_t;
  typedef enum logic [1:0] {
    EN_UNS = 2'h0, EN_SGN = 2'h1, EN_IEEE = 2'h2
  } fvm_enc_t;
  typedef enum logic [1:0] {
    RK_OK = 2'h0, RK_ACK = 2'h1, RK_ERR = 2'h2
  } fvm_rsp_kind_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_REQ = 2'h1, ST_WAIT = 2'h2
  } fvm_state_t;

  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [1:0] qty;
    logic [15:0] d0;
    logic [15:0] d1;
  } fvm_req_t;
  typedef struct packed {
    fvm_rsp_kind_t kind;
    logic [15:0] d0;
    logic [15:0] d1;
  } fvm_rsp_t;
  typedef struct packed {
    logic en;
    logic dir;
    fvm_type_t ty;
    fvm_area_t area;
    logic lofirst;
    fvm_enc_t enc;
    logic wr_single;
    logic [4:0] cnt;
    logic [3:0] off;
    logic [2:0] act;
    logic [15:0] addr;
    logic [31:0] thr;
    logic [31:0] vhi;
    logic [31:0] veq;
    logic [31:0] vlo;
    logic [31:0] kmin;
    logic [31:0] kmax;
    logic [31:0] rmin;
    logic [31:0] rmax;
  } fvm_cfg_t;
  localparam fvm_cfg_t CFG_RST = '{en: 1'b0, dir: 1'b0, ty: TY_UNS,
    area: AR_FULL_U, lofirst: 1'b0, enc: EN_UNS, wr_single: 1'b0,
    cnt: 5'h10, off: 4'h0, act: 3'h0, addr: 16'h0000, thr: 32'h0,
    vhi: 32'h0, veq: 32'h0, vlo: 32'h0, kmin: 32'h0, kmax: 32'h1,
    rmin: 32'h0, rmax: 32'h1};
endpackage : fvm_pkg

/* File: testbench/fvm_mb_slave.sv */
// Modbus slave stand-in on the channel's request and answer port.
// Assumes requests are held until taken; answers after a delay fixed per mode, none in mode 2.
`timescale 1ns/10ps
module fvm_mb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mb_req_valid,
  output logic mb_req_ready,
  input wire fvm_pkg::fvm_req_t mb_req,
  output logic mb_rsp_valid,
  output fvm_pkg::fvm_rsp_t mb_rsp,
  input wire logic [1:0] mode,
  output fvm_pkg::fvm_req_t last,
  output int n_req
);
  import fvm_pkg::*;
  localparam logic [15:0] D0 = 16'h0123;
  localparam logic [15:0] D1 = 16'h4567;
  logic busy_r;
  int cnt_r;
  // Ready only on alternate idle cycles, so requests must wait to be taken
  assign mb_req_ready = ~busy_r & cnt_r[0];
  // Mode 0 prompt, mode 1 slow with acknowledge, mode 2 silent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      cnt_r <= 0;
      n_req <= 0;
      last <= '0;
      mb_rsp_valid <= 1'b0;
      mb_rsp <= '0;
    end else begin
      mb_rsp_valid <= 1'b0;
      mb_rsp.d0 <= ~mb_rsp.d0;
      mb_rsp.d1 <= ~mb_rsp.d1;
      cnt_r <= cnt_r + 1;
      if (mb_req_valid && mb_req_ready) begin
        busy_r <= (mode != 2'h2);
        cnt_r <= 0;
        last <= mb_req;
        n_req <= n_req + 1;
      end else if (busy_r && mode == 2'h1 && cnt_r == 15) begin
        mb_rsp_valid <= 1'b1;
        mb_rsp <= '{RK_ACK, 16'h0000, 16'h0000};
      end else if (busy_r && cnt_r == (mode == 2'h1 ? 30 : 3)) begin
        busy_r <= 1'b0;
        mb_rsp_valid <= 1'b1;
        mb_rsp <= '{RK_OK, D0, D1};
      end
    end
  end
endmodule : fvm_mb_slave

/* File: testbench/tb_fvm_channel.sv */
// Self-checking bench for the field value mapping channel.
// Assumes a 40 MHz clock and a shortened answer timeout.
`timescale 1ns/10ps
module tb_fvm_channel;
  import fvm_pkg::*;
  localparam int TO = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, knx_rx_valid = 1'b0, page_skip_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, knx_rx_value = 32'h0, tx_seen = 32'h0;
  logic [31:0] prdata, rd, knx_tx_value;
  logic pready, pslverr, err, knx_rx_ready, knx_tx_valid, mb_req_valid;
  logic mb_req_ready, mb_rsp_valid, page_skip_out, skip_seen = 1'b0;
  logic [1:0] mode = 2'h0;
  fvm_req_t mb_req, last;
  fvm_rsp_t mb_rsp;
  int n_req, n0, n_errors = 0, compares = 0;
  always #12.5 pclk = ~pclk;
  fvm_channel #(.TIMEOUT_CYC(TO)) fvm_channel_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .knx_rx_valid(knx_rx_valid),
    .knx_rx_value(knx_rx_value), .knx_rx_ready(knx_rx_ready),
    .knx_tx_valid(knx_tx_valid), .knx_tx_value(knx_tx_value),
    .mb_req_valid(mb_req_valid), .mb_req_ready(mb_req_ready),
    .mb_req(mb_req), .mb_rsp_valid(mb_rsp_valid), .mb_rsp(mb_rsp),
    .page_skip_in(page_skip_in), .page_skip_out(page_skip_out));
  fvm_mb_slave fvm_mb_slave_i (.pclk(pclk), .presetn(presetn),
    .mb_req_valid(mb_req_valid), .mb_req_ready(mb_req_ready),
    .mb_req(mb_req), .mb_rsp_valid(mb_rsp_valid), .mb_rsp(mb_rsp),
    .mode(mode), .last(last), .n_req(n_req));
  always @(posedge pclk) begin
    if (knx_tx_valid === 1'b1) tx_seen <= knx_tx_value;
    if (page_skip_out === 1'b1) skip_seen <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wt;
    repeat (2) @(posedge pclk);
    while (knx_rx_ready !== 1'b1 || mb_req_valid !== 1'b0) @(posedge pclk);
    @(posedge pclk);
  endtask : wt
  task automatic knx(input logic [31:0] v);
    n0 = n_req;
    knx_rx_value <= v;
    knx_rx_valid <= 1'b1;
    do @(posedge pclk); while (knx_rx_ready !== 1'b1);
    knx_rx_valid <= 1'b0;
    wt();
  endtask : knx
  task automatic end_of_test;
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    #(25 * 8000);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_FIELD, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, A_ADDR, 32'h7);
    apb(1'b1, A_CTRL, 32'h05);
    apb(1'b1, A_FIELD, 32'h0404);
    knx(32'h5);
    chk(32'(last.func), 32'(FC_WR_SINGLE));
    chk(32'(last.d0), 32'h0050);
    apb(1'b1, A_FIELD, 32'h080A);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[0]), 32'h1);
    knx(32'h5);
    chk(32'(n_req - n0), 32'h0);
    apb(1'b1, A_FIELD, 32'h0C04);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[0]), 32'h0);
    knx(32'h5);
    chk(32'(last.d0 & 16'hF000), 32'h5000);
    apb(1'b1, A_CTRL, 32'h09);
    knx(32'hFFFF_FFFE);
    chk(32'(last.d0), 32'hFFFE);
    apb(1'b1, A_KMAX, 32'hA);
    apb(1'b1, A_RMAX, 32'h64);
    apb(1'b1, A_CTRL, 32'h4D);
    knx(32'h14);
    chk(32'(last.d0), 32'h00C8);
    apb(1'b1, A_CTRL, 32'h2D);
    knx(32'h3);
    chk(32'(last.d0[15:8]), 32'h1E);
    apb(1'b1, A_CTRL, 32'h411);
    knx(32'h1234_5678);
    chk(32'(last.func), 32'(FC_WR_MULTI));
    chk({last.d0, last.d1}, 32'h1234_5678);
    chk(32'(last.qty), 32'h2);
    apb(1'b1, A_CTRL, 32'hD11);
    knx(32'h1234_5678);
    chk(32'(n_req - n0), 32'h2);
    chk({last.addr, last.d0}, 32'h0008_1234);
    apb(1'b1, A_CTRL, 32'h01);
    apb(1'b1, A_FIELD, 32'h0004);
    apb(1'b1, A_THR, 32'hA);
    apb(1'b1, A_VHI, 32'h3);
    apb(1'b1, A_VLO, 32'h1);
    apb(1'b1, A_ACT, 32'h5);
    apb(1'b1, A_VHI, 32'h13);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[0]), 32'h1);
    apb(1'b1, A_VHI, 32'h3);
    knx(32'hB);
    chk(32'(last.d0[3:0]), 32'h3);
    knx(32'hA);
    chk(32'(n_req - n0), 32'h0);
    knx(32'h9);
    chk(32'(last.d0[3:0]), 32'h1);
    mode <= 2'h1;
    apb(1'b1, A_CTRL, 32'h413);
    apb(1'b1, A_POLL, 32'h1);
    n0 = n_req;
    wt();
    chk(tx_seen, 32'h0123_4567);
    chk({last.func, 6'h0, last.qty}, 32'h0302);
    chk(32'(n_req - n0), 32'h1);
    mode <= 2'h2;
    apb(1'b1, A_CTRL, 32'h411);
    knx(32'h1);
    chk(32'(n_req - n0), 32'h3);
    apb(1'b0, A_STAT, 32'h0);
    chk({30'h0, rd[1], skip_seen}, 32'h3);
    knx(32'h1);
    chk(32'(n_req - n0), 32'h0);
    apb(1'b1, A_STAT, 32'h2);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[1]), 32'h0);
    page_skip_in <= 1'b1;
    @(posedge pclk);
    page_skip_in <= 1'b0;
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[1]), 32'h1);
    end_of_test();
  end
endmodule : tb_fvm_channel
